// file: inc/ctm_pkg.sv
package ctm_pkg;

  localparam int CTM_CNT_W = 10;
  localparam int CTM_PER_W = 3;

  // avalon word offsets (byte addresses)
  localparam logic [4:0] CTM_OFS_CTRL0   = 5'h00;
  localparam logic [4:0] CTM_OFS_CTRL1   = 5'h04;
  localparam logic [4:0] CTM_OFS_CNT_LO  = 5'h08;
  localparam logic [4:0] CTM_OFS_CNT_HI  = 5'h0c;
  localparam logic [4:0] CTM_OFS_CMP_LO  = 5'h10;
  localparam logic [4:0] CTM_OFS_CMP_HI  = 5'h14;
  localparam logic [4:0] CTM_OFS_STATUS  = 5'h18;

  // control 0 fields
  localparam int CTM_C0_PER_LSB   = 0;
  localparam int CTM_C0_RUN       = 3;
  localparam int CTM_C0_CLK_LSB   = 4;
  localparam int CTM_C0_PAUSE     = 7;
  // control 1 fields
  localparam int CTM_C1_CLR_SRC   = 0;
  localparam int CTM_C1_DPX       = 1;
  localparam int CTM_C1_POL       = 2;
  localparam int CTM_C1_OC        = 3;
  localparam int CTM_C1_IO_LSB    = 4;
  localparam int CTM_C1_MODE_LSB  = 6;

  localparam logic [7:0] CTM_CTRL_RST = 8'h00;
  localparam logic [9:0] CTM_CMP_RST  = 10'h000;

  // divider counts for the internal sources
  localparam logic [5:0] CTM_DIV_SYS4  = 6'h03;
  localparam logic [5:0] CTM_DIV_H16   = 6'h0f;
  localparam logic [5:0] CTM_DIV_H64   = 6'h3f;
  localparam logic [5:0] CTM_DIV_SUB   = 6'h3f;

  typedef enum logic [1:0] {
    CTM_MODE_CMP   = 2'b00,
    CTM_MODE_UNDEF = 2'b01,
    CTM_MODE_PWM   = 2'b10,
    CTM_MODE_TIMER = 2'b11
  } ctm_mode_t;

  typedef enum logic [2:0] {
    CTM_CLK_SYS4 = 3'b000,
    CTM_CLK_SYS  = 3'b001,
    CTM_CLK_H16  = 3'b010,
    CTM_CLK_H64  = 3'b011,
    CTM_CLK_SUB0 = 3'b100,
    CTM_CLK_SUB1 = 3'b101,
    CTM_CLK_EXTR = 3'b110,
    CTM_CLK_EXTF = 3'b111
  } ctm_clk_t;

endpackage

// file: verilog/ctm_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
module ctm_tick_gen
  import ctm_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] clock_source_select_in,
  input  wire logic       ext_count_clock_in,
  output logic            tick_out
);

  logic [1:0] ext_sync_ff;
  logic       ext_prev_ff;
  logic [5:0] div_ff;
  logic [5:0] sub_div_ff;
  logic       sub_tick;
  logic       ext_rise;
  logic       ext_fall;

  // pin is asynchronous: two stages, then edge detect on the second
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ext_sync_ff <= 2'b00;
      ext_prev_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[0], ext_count_clock_in};
      ext_prev_ff <= ext_sync_ff[1];
    end
  end

  assign ext_rise = ext_sync_ff[1] & ~ext_prev_ff;
  assign ext_fall = ~ext_sync_ff[1] & ext_prev_ff;

  // free dividers; core clock stands in for the high clock
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      div_ff     <= 6'h00;
      sub_div_ff <= 6'h00;
    end else begin
      div_ff <= div_ff + 6'h01;
      if (div_ff == CTM_DIV_H64) begin
        sub_div_ff <= sub_div_ff + 6'h01;
      end
    end
  end

  assign sub_tick = (div_ff == CTM_DIV_H64) && (sub_div_ff == CTM_DIV_SUB);

  always_comb begin
    case (ctm_clk_t'(clock_source_select_in))
      CTM_CLK_SYS4: tick_out = ((div_ff & CTM_DIV_SYS4) == CTM_DIV_SYS4);
      CTM_CLK_SYS:  tick_out = 1'b1;
      CTM_CLK_H16:  tick_out = ((div_ff & CTM_DIV_H16) == CTM_DIV_H16);
      CTM_CLK_H64:  tick_out = (div_ff == CTM_DIV_H64);
      CTM_CLK_SUB0: tick_out = sub_tick;
      CTM_CLK_SUB1: tick_out = sub_tick;
      CTM_CLK_EXTR: tick_out = ext_rise;
      CTM_CLK_EXTF: tick_out = ext_fall;
      default:      tick_out = 1'b0;
    endcase
  end

  a_ext_rise_tick: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (clock_source_select_in == CTM_CLK_EXTR) && $rose(ext_sync_ff[1]) |-> tick_out)
    else $error("rising pin edge gave no count tick");

endmodule // ctm_tick_gen
`default_nettype wire

// file: verilog/ctm_output_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module ctm_output_ctl
  import ctm_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       run_start_in,
  input  wire logic       running_in,
  input  wire logic [1:0] mode_in,
  input  wire logic [1:0] io_sel_in,
  input  wire logic       init_level_in,
  input  wire logic       invert_in,
  input  wire logic       cmp_a_match_in,
  input  wire logic       pwm_active_in,
  output logic            timer_output_pin_out
);

  logic pin_ff;
  logic nxt_pin;

  always_comb begin
    nxt_pin = pin_ff;
    if (run_start_in) begin
      nxt_pin = init_level_in;
    end else if (running_in) begin
      case (ctm_mode_t'(mode_in))
        CTM_MODE_CMP: begin
          if (cmp_a_match_in) begin
            case (io_sel_in)
              2'b01:   nxt_pin = 1'b0;
              2'b10:   nxt_pin = 1'b1;
              2'b11:   nxt_pin = ~pin_ff;
              default: nxt_pin = pin_ff;
            endcase
          end
        end
        CTM_MODE_PWM: begin
          case (io_sel_in)
            2'b00:   nxt_pin = ~init_level_in;
            2'b01:   nxt_pin = init_level_in;
            2'b10:   nxt_pin = pwm_active_in ? init_level_in : ~init_level_in;
            default: nxt_pin = pin_ff;
          endcase
        end
        default: nxt_pin = pin_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign timer_output_pin_out = pin_ff ^ invert_in;

  a_toggle_match: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    running_in && !run_start_in && mode_in == CTM_MODE_CMP && io_sel_in == 2'b11
      && cmp_a_match_in |=> pin_ff != $past(pin_ff))
    else $error("compare match did not toggle the pin");

endmodule // ctm_output_ctl
`default_nettype wire

// file: verilog/ctm_top.sv
// Behaviour
// - counter compared with comparators; equality raises interrupt, may clear, drives pin
// - count clock chosen from divided system, high, low-speed or external pin
// - separate interrupt pulses for comparator A and comparator P matches
// - external pin counts on rising or falling edge as configured
// - compare output mode sets pin high, low or toggles on match
// - pwm waveform appears on the same output pin
// - compare low-byte write fills buffer; compare high-byte write commits both bytes
// - high-byte read captures low byte into buffer; low read returns buffer
// - core is a ten-bit counter advancing once per selected clock event
// - period value is three bits, compared with top three counter bits
// - full compare value is ten bits, compared with every counter bit
// - software only clears counter, by raising the run bit
// - counter clears on overflow or selected match, raising its interrupt
// - modes: compare match output, timer/event counter, pwm output
// - period field matches bits 9..7; zero means 1024 clocks
// - clear source bit: 0 period comparator, 1 full comparator
// - run rise zeroes counter; run fall holds residual value
// - three-bit clock select; 110 pin rising, 111 pin falling
`timescale 1ns/1ns
`default_nettype none
module ctm_top
  import ctm_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [1:0]       avs_response_out,
  input  wire logic        ext_count_clock_in,
  output logic             timer_output_pin_out,
  output logic             irq_cmp_a_out,
  output logic             irq_cmp_p_out
);

  logic [7:0]  ctrl0_ff;
  logic [7:0]  ctrl1_ff;
  logic [9:0]  full_compare_value_ff;
  logic [7:0]  byte_buf_ff;
  logic [9:0]  count_ff;
  logic        run_prev_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  resp_ff;
  logic [1:0]  a_seen_ff;
  logic [1:0]  p_seen_ff;

  logic        counter_run_enable;
  logic        pause;
  logic [2:0]  period_compare_field;
  logic [2:0]  clock_source_select;
  logic        clear_source_select;
  logic        run_start;
  logic        tick;
  logic        advance;
  logic        cmp_a_hit;
  logic        cmp_p_hit;
  logic        overflow;
  logic        clear_now;
  logic        pwm_active;
  logic        access;
  logic        wr_lo;
  logic        wr_hi;

  assign period_compare_field = ctrl0_ff[CTM_C0_PER_LSB +: CTM_PER_W];
  assign counter_run_enable   = ctrl0_ff[CTM_C0_RUN];
  assign clock_source_select  = ctrl0_ff[CTM_C0_CLK_LSB +: 3];
  assign pause                = ctrl0_ff[CTM_C0_PAUSE];
  assign clear_source_select  = ctrl1_ff[CTM_C1_CLR_SRC];

  function automatic logic addr_is(input logic [4:0] a, input logic [4:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // ---- count clock
  ctm_tick_gen u_tick (
    .core_clk_in            (core_clk_in),
    .rst_n_in               (rst_n_in),
    .clock_source_select_in (clock_source_select),
    .ext_count_clock_in     (ext_count_clock_in),
    .tick_out               (tick)
  );

  // ---- counter and comparators
  assign run_start = counter_run_enable & ~run_prev_ff;
  assign advance   = counter_run_enable & ~pause & tick;
  // compare on the value the counter holds when the next tick arrives
  assign cmp_a_hit = advance && (count_ff == full_compare_value_ff);
  // hit on the tick that carries bits 9..7 up to the field, so the period is field*128
  // field zero wraps to 3'h7 and coincides with overflow: 1024 clocks
  assign cmp_p_hit = advance && (count_ff[6:0] == 7'h7f)
                     && (count_ff[9:7] == period_compare_field - 3'h1);
  assign overflow  = advance && (count_ff == 10'h3ff);
  assign clear_now = overflow
                   || (clear_source_select ? cmp_a_hit : cmp_p_hit);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      run_prev_ff <= 1'b0;
    end else begin
      run_prev_ff <= counter_run_enable;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      count_ff <= 10'h000;
    end else if (run_start) begin
      count_ff <= 10'h000;
    end else if (clear_now) begin
      count_ff <= 10'h000;
    end else if (advance) begin
      count_ff <= count_ff + 10'h001;
    end
  end

  // interrupt pulses; with field zero the period hit is the overflow itself
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_cmp_a_out <= 1'b0;
      irq_cmp_p_out <= 1'b0;
    end else begin
      irq_cmp_a_out <= cmp_a_hit;
      irq_cmp_p_out <= cmp_p_hit;
    end
  end

  // edge pwm: ctrl1 dpx selects duty only (0 -> A, 1 -> P); period follows the clear source bit
  always_comb begin
    if (ctrl1_ff[CTM_C1_DPX]) begin
      pwm_active = (count_ff[9:7] < period_compare_field);
    end else begin
      pwm_active = (count_ff < full_compare_value_ff);
    end
  end

  // ---- output pin
  ctm_output_ctl u_out (
    .core_clk_in          (core_clk_in),
    .rst_n_in             (rst_n_in),
    .run_start_in         (run_start),
    .running_in           (counter_run_enable),
    .mode_in              (ctrl1_ff[CTM_C1_MODE_LSB +: 2]),
    .io_sel_in            (ctrl1_ff[CTM_C1_IO_LSB +: 2]),
    .init_level_in        (ctrl1_ff[CTM_C1_OC]),
    .invert_in            (ctrl1_ff[CTM_C1_POL]),
    .cmp_a_match_in       (cmp_a_hit),
    .pwm_active_in        (pwm_active),
    .timer_output_pin_out (timer_output_pin_out)
  );

  // ---- avalon slave: one wait cycle, then answer
  assign access              = (avs_read_in | avs_write_in) & ~ack_ff;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
  assign avs_readdata_out    = rdata_ff;
  assign avs_response_out    = resp_ff;
  assign wr_lo = access && avs_write_in && avs_byteenable_in[0];
  assign wr_hi = wr_lo && addr_is(avs_address_in, CTM_OFS_CMP_HI);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= access;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl0_ff              <= CTM_CTRL_RST;
      ctrl1_ff              <= CTM_CTRL_RST;
      full_compare_value_ff <= CTM_CMP_RST;
    end else if (wr_lo) begin
      if (addr_is(avs_address_in, CTM_OFS_CTRL0)) begin
        ctrl0_ff <= avs_writedata_in[7:0];
      end
      if (addr_is(avs_address_in, CTM_OFS_CTRL1)) begin
        ctrl1_ff <= avs_writedata_in[7:0];
      end
      if (wr_hi) begin
        full_compare_value_ff <= {avs_writedata_in[1:0], byte_buf_ff};
      end
    end
  end

  // shared low-byte buffer
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      byte_buf_ff <= 8'h00;
    end else if (wr_lo && addr_is(avs_address_in, CTM_OFS_CMP_LO)) begin
      byte_buf_ff <= avs_writedata_in[7:0];
    end else if (access && avs_read_in) begin
      if (addr_is(avs_address_in, CTM_OFS_CNT_HI)) begin
        byte_buf_ff <= count_ff[7:0];
      end else if (addr_is(avs_address_in, CTM_OFS_CMP_HI)) begin
        byte_buf_ff <= full_compare_value_ff[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h0000_0000;
      resp_ff  <= 2'b00;
    end else if (access) begin
      rdata_ff <= 32'h0000_0000;
      resp_ff  <= 2'b00;
      if (avs_read_in) begin
        case (avs_address_in)
          CTM_OFS_CTRL0:  rdata_ff[7:0] <= ctrl0_ff;
          CTM_OFS_CTRL1:  rdata_ff[7:0] <= ctrl1_ff;
          CTM_OFS_CNT_LO: rdata_ff[7:0] <= byte_buf_ff;
          CTM_OFS_CNT_HI: rdata_ff[1:0] <= count_ff[9:8];
          CTM_OFS_CMP_LO: rdata_ff[7:0] <= byte_buf_ff;
          CTM_OFS_CMP_HI: rdata_ff[1:0] <= full_compare_value_ff[9:8];
          CTM_OFS_STATUS: rdata_ff[1:0] <= {pwm_active, counter_run_enable};
          default:        resp_ff <= 2'b10;
        endcase
      end else if (!(avs_address_in inside {CTM_OFS_CTRL0, CTM_OFS_CTRL1,
                     CTM_OFS_CNT_LO, CTM_OFS_CNT_HI, CTM_OFS_CMP_LO,
                     CTM_OFS_CMP_HI, CTM_OFS_STATUS})) begin
        resp_ff <= 2'b10;
      end
    end
  end

  // ---- checks
  sequence s_run_rise;
    !run_prev_ff ##0 counter_run_enable;
  endsequence

  a_run_clears: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_run_rise |=> count_ff == 10'h000)
    else $error("run rise did not zero the counter");

  a_hold_stopped: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !counter_run_enable && !$past(counter_run_enable) |-> $stable(count_ff))
    else $error("counter moved while stopped");

  a_count_step: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    advance && !clear_now && !run_start |=> count_ff == $past(count_ff) + 10'h001)
    else $error("counter did not advance by one");

  a_irq_a_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmp_a_hit |=> irq_cmp_a_out)
    else $error("comparator a match gave no interrupt");

  a_clear_on_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    clear_source_select && cmp_a_hit && !run_start |=> count_ff == 10'h000)
    else $error("full comparator match did not clear");

  a_clear_on_p: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !clear_source_select && cmp_p_hit && !run_start |=> count_ff == 10'h000 ##0 irq_cmp_p_out)
    else $error("period match did not clear with interrupt");

  a_overflow_wrap: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    overflow |=> count_ff == 10'h000)
    else $error("overflow did not wrap to zero");

  a_buf_commit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_hi |=> full_compare_value_ff[7:0] == $past(byte_buf_ff))
    else $error("high write did not commit buffered low byte");

  a_hi_read_buf: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    access && avs_read_in && addr_is(avs_address_in, CTM_OFS_CNT_HI)
      |=> byte_buf_ff == $past(count_ff[7:0]))
    else $error("high read did not capture low byte");

endmodule // ctm_top
`default_nettype wire

// file: verification/ctm_ext_clk_model.sv
`timescale 1ns/1ns
`default_nettype none
module ctm_ext_clk_model (
  input  wire logic       core_clk_in,
  input  wire logic       start_in,
  input  wire logic [7:0] count_in,
  input  wire logic [3:0] half_in,
  output logic            pin_out,
  output logic            busy_out
);
  int edges_left = 0;
  int hold       = 0;
  initial pin_out = 1'b0;
  initial busy_out = 1'b0;
  // pin parks low between bursts; a burst of n pulses gives n rising and n falling edges
  always @(posedge core_clk_in) begin
    if (start_in) begin
      edges_left <= 2 * count_in;
      hold       <= half_in;
      busy_out   <= 1'b1;
    end else if (edges_left > 0) begin
      if (hold == 0) begin
        pin_out    <= ~pin_out;
        edges_left <= edges_left - 1;
        hold       <= half_in;
      end else begin
        hold <= hold - 1;
      end
    end else begin
      busy_out <= 1'b0;
    end
  end
endmodule // ctm_ext_clk_model
`default_nettype wire

// file: verification/compact_timer_module_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module compact_timer_module_tb_top
  import ctm_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h1;
  logic [31:0] rdata;
  logic        waitreq;
  logic [1:0]  resp;
  logic        ext_pin;
  logic        pin;
  logic        irq_a;
  logic        irq_p;
  logic        m_start = 1'b0;
  logic [7:0]  m_cnt = 8'h00;
  logic [3:0]  m_half = 4'h1;
  logic        m_busy;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  int          m_cmp = 0;
  int          divs[$] = '{int'(CTM_DIV_SYS4) + 1, 1, int'(CTM_DIV_H16) + 1, int'(CTM_DIV_H64) + 1};
  logic [3:0]  oc[4] = '{4'b0110, 4'b1000, 4'b1101, 4'b0000};
  logic        oc_exp[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int          fs[3] = '{1, 3, 0};

  always #50 clk = ~clk;
  always @(posedge clk) cyc_cnt++;

  ctm_top uut (
    .core_clk_in          (clk),
    .rst_n_in             (rst_n),
    .avs_address_in       (addr),
    .avs_read_in          (rd_en),
    .avs_write_in         (wr_en),
    .avs_writedata_in     (wdata),
    .avs_byteenable_in    (be),
    .avs_readdata_out     (rdata),
    .avs_waitrequest_out  (waitreq),
    .avs_response_out     (resp),
    .ext_count_clock_in   (ext_pin),
    .timer_output_pin_out (pin),
    .irq_cmp_a_out        (irq_a),
    .irq_cmp_p_out        (irq_p)
  );

  ctm_ext_clk_model ext_src (
    .core_clk_in (clk),
    .start_in    (m_start),
    .count_in    (m_cnt),
    .half_in     (m_half),
    .pin_out     (ext_pin),
    .busy_out    (m_busy)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // entered just after a rising edge; request held until waitrequest is seen low
  task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q, output logic [1:0] r);
    int n;
    n = 0;
    addr  <= a;
    wr_en <= w;
    rd_en <= ~w;
    wdata <= {24'h0, d};
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) failures++;
    q = rdata[7:0];
    r = resp;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [1:0] r;
    xfer(a, 1'b1, d, q, r);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    logic [1:0] r;
    xfer(a, 1'b0, 8'h00, q, r);
    check(32'(r), 32'h0);
  endtask

  task automatic set_cmp(input int v);
    wr(CTM_OFS_CMP_LO, 8'(v));
    wr(CTM_OFS_CMP_HI, 8'(v >> 8));
    m_cmp = v % 1024;
  endtask

  task automatic read_cnt(output int v);
    logic [7:0] h;
    logic [7:0] l;
    rd(CTM_OFS_CNT_HI, h);
    rd(CTM_OFS_CNT_LO, l);
    v = {h[1:0], l};
  endtask

  task automatic wait_irq(input logic sel_p, output int t);
    int n;
    n = 0;
    @(negedge clk);
    while ((sel_p ? irq_p : irq_a) !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) failures++;
    t = cyc_cnt;
    @(posedge clk);
  endtask

  task automatic pin_is(input logic exp);
    @(negedge clk);
    check(32'(pin), 32'(exp));
    @(posedge clk);
  endtask

  initial begin
    cyc(40000);
    failures++;
    tally_and_finish();
  end

  initial begin
    int t0;
    int t1;
    int v;
    int n;
    logic [7:0] q;
    logic [7:0] h;
    logic [1:0] r;
    void'($urandom(1));
    cyc(8);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rd(5'(i * 4), q);
      check(32'(q), 32'h0);
    end
    xfer(5'h1c, 1'b0, 8'h00, q, r);
    check(32'(r), 32'h2);
    check(32'(q), 32'h0);
    $display("test reset_and_map done");

    for (int i = 0; i < 4; i++) begin
      set_cmp($urandom % 1024);
      wr(CTM_OFS_CMP_LO, 8'($urandom)); // stray low write must stay in the buffer
      rd(CTM_OFS_CMP_HI, h);
      rd(CTM_OFS_CMP_LO, q);
      check(32'({h[1:0], q}), 32'(m_cmp));
    end
    $display("test byte_pairs done");

    wr(CTM_OFS_CTRL1, 8'hc1);
    set_cmp(20 + $urandom % 80);
    wr(CTM_OFS_CTRL0, 8'h18);
    wait_irq(1'b0, t0);
    wait_irq(1'b0, t1);
    check(32'(t1 - t0), 32'(m_cmp + 1));
    wr(CTM_OFS_CTRL0, 8'h00);
    wr(CTM_OFS_CTRL1, 8'hc0);
    for (int i = 0; i < 3; i++) begin
      wr(CTM_OFS_CTRL0, 8'(8'h18 | fs[i]));
      wait_irq(1'b1, t0);
      wait_irq(1'b1, t1);
      check(32'(t1 - t0), 32'(fs[i] == 0 ? 1024 : 128 * fs[i]));
      wr(CTM_OFS_CTRL0, 8'h00);
    end
    $display("test match_periods done");

    for (int i = 0; i < 4; i++) begin
      wr(CTM_OFS_CTRL0, {1'b0, 3'(i), 4'h8});
      cyc(divs[i] * 16);
      wr(CTM_OFS_CTRL0, 8'h00);
      read_cnt(v);
      // stop write lands the wait plus three cycles after the start write
      n = (divs[i] * 16 + 3) / divs[i];
      check(32'(v >= n - 1 && v <= n + 1), 32'h1);
    end
    $display("test internal_clocks done");

    for (int e = 0; e < 2; e++) begin
      wr(CTM_OFS_CTRL0, e ? 8'h78 : 8'h68);
      m_cnt <= 8'(5 + $urandom % 40);
      m_half <= 4'(1 + $urandom % 8);
      m_start <= 1'b1;
      @(posedge clk);
      m_start <= 1'b0;
      @(negedge clk);
      n = 0;
      while (m_busy !== 1'b0 && n < 5000) begin
        @(negedge clk);
        n++;
      end
      cyc(8);
      wr(CTM_OFS_CTRL0, 8'h00);
      wr(CTM_OFS_CNT_LO, 8'hff);
      wr(CTM_OFS_CNT_HI, 8'h03);
      read_cnt(v);
      check(32'(v), 32'(m_cnt));
      wr(CTM_OFS_CTRL0, 8'he8);
      read_cnt(v);
      check(32'(v), 32'h0);
      wr(CTM_OFS_CTRL0, 8'h00);
    end
    $display("test ext_clock done");

    set_cmp(30);
    for (int i = 0; i < 4; i++) begin
      wr(CTM_OFS_CTRL1, {2'b00, oc[i], 2'b01});
      wr(CTM_OFS_CTRL0, 8'h18);
      pin_is(oc[i][1] ^ oc[i][0]);
      wait_irq(1'b0, t0);
      cyc(3);
      pin_is(oc_exp[i]);
      wr(CTM_OFS_CTRL0, 8'h00);
    end
    $display("test compare_output done");

    wr(CTM_OFS_CTRL1, 8'ha8);
    set_cmp(32);
    wr(CTM_OFS_CTRL0, 8'h19);
    cyc(300);
    v = 0;
    repeat (1280) begin
      @(negedge clk);
      v += (pin === 1'b1);
    end
    @(posedge clk);
    check(32'(v), 32'd320);
    rd(CTM_OFS_STATUS, q);
    check(32'(q[0]), 32'h1);
    $display("test pwm_output done");
    tally_and_finish();
  end
endmodule // compact_timer_module_tb_top
`default_nettype wire
